/* File: rtl/tcr_timer16_regs.sv */
// Byte-wide register file of the 16-bit timer with shared high-byte latch.
`timescale 1ns/1ps
module tcr_timer16_regs
   import tcr_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   input  wire logic        clk_en_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o,
   input  wire logic        tick_i,
   input  wire logic        run_i,
   input  wire logic        top_is_capture_i,
   input  wire logic [15:0] top_i,
   input  wire logic        capture_input_pin_i,
   input  wire logic        comparator_i,
   input  wire logic        use_comparator_i,
   input  wire logic        capture_edge_select_i,
   input  wire logic        global_irq_enable_i,
   input  wire logic [3:0]  vector_ack_i,
   output logic [15:0]      running_count_o,
   output logic [15:0]      capture_value_o,
   output logic             match_a_o,
   output logic             match_b_o,
   output logic             capture_event_o,
   output logic [7:0]       flags_o,
   output logic [3:0]       irq_o
);
   logic [7:0]  shadow_q;
   logic [15:0] count_q;
   logic [15:0] capture_q;
   logic [15:0] cmpa_q;
   logic [15:0] cmpb_q;
   logic [7:0]  mask_q;
   logic [7:0]  flags_q;
   logic [7:0]  rdata_q;
   logic        block_q;
   logic        wr_count;
   logic        cap_edge;
   logic        cap_src;
   logic        cap_evt;
   logic        at_top;
   logic        wrap_evt;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;

   assign wr_count = wr_i & ((addr_i == TCR_OFS_COUNT_LO) |
                             (addr_i == TCR_OFS_COUNT_HI));

   assign cap_src = use_comparator_i ? comparator_i : capture_input_pin_i;

   tcr_edge_detect u_edge (
      .mclk_i   (mclk_i),
      .rstn_i   (rstn_i),
      .en_i     (clk_en_i),
      .level_i  (cap_src),
      .rising_i (capture_edge_select_i),
      .edge_o   (cap_edge)
   );

   assign cap_evt = cap_edge & ~top_is_capture_i;
   assign at_top  = count_q == (top_is_capture_i ? capture_q : top_i);
   assign wrap_evt = tick_i & run_i & (count_q == TCR_COUNT_MAX) &
                     ~top_is_capture_i;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         block_q <= 1'b0;
      end else if (clk_en_i) begin
         if (wr_count) begin
            block_q <= 1'b1;
         end else if (tick_i) begin
            block_q <= 1'b0;
         end
      end
   end

   tcr_compare_unit u_cmpa (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .en_i      (clk_en_i),
      .tick_i    (tick_i),
      .block_i   (block_q | wr_count),
      .count_i   (count_q),
      .compare_i (cmpa_q),
      .match_o   (match_a_o)
   );

   tcr_compare_unit u_cmpb (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .en_i      (clk_en_i),
      .tick_i    (tick_i),
      .block_i   (block_q | wr_count),
      .count_i   (count_q),
      .compare_i (cmpb_q),
      .match_o   (match_b_o)
   );

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shadow_q <= TCR_RST_BYTE;
      end else if (clk_en_i) begin
         if (wr_i && (addr_i == TCR_OFS_COUNT_HI ||
                      addr_i == TCR_OFS_CAPT_HI ||
                      addr_i == TCR_OFS_CMPA_HI ||
                      addr_i == TCR_OFS_CMPB_HI)) begin
            shadow_q <= wdata_i;
         end else if (rd_i && addr_i == TCR_OFS_COUNT_LO) begin
            shadow_q <= count_q[15:8];
         end else if (rd_i && addr_i == TCR_OFS_CAPT_LO) begin
            // capture high latched on low read
            shadow_q <= capture_q[15:8];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_q <= TCR_RST_WORD;
      end else if (clk_en_i) begin
         if (wr_i && addr_i == TCR_OFS_COUNT_LO) begin
            count_q <= {shadow_q, wdata_i};
         end else if (tick_i && run_i) begin
            if (at_top && top_is_capture_i) begin
               count_q <= TCR_RST_WORD;
            end else begin
               count_q <= count_q + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         capture_q <= TCR_RST_WORD;
      end else if (clk_en_i) begin
         if (wr_i && addr_i == TCR_OFS_CAPT_LO) begin
            capture_q <= {shadow_q, wdata_i};
         end else if (cap_evt) begin
            capture_q <= count_q;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmpa_q <= TCR_RST_WORD;
         cmpb_q <= TCR_RST_WORD;
      end else if (clk_en_i) begin
         if (wr_i && addr_i == TCR_OFS_CMPA_LO) begin
            cmpa_q <= {shadow_q, wdata_i};
         end
         if (wr_i && addr_i == TCR_OFS_CMPB_LO) begin
            cmpb_q <= {shadow_q, wdata_i};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_q <= TCR_RST_BYTE;
      end else if (clk_en_i && wr_i && addr_i == TCR_OFS_IRQ_MASK) begin
         mask_q <= wdata_i & TCR_MASK_VALID;
      end
   end

   // flag rises with match pulse
   // Taken from the same equality term as the match so both land together.
   always_comb begin
      flag_set = 8'h00;
      flag_set[TCR_BIT_CAPT] = cap_evt |
                               (top_is_capture_i & tick_i & run_i & at_top);
      flag_set[TCR_BIT_CMPB] = tick_i & ~(block_q | wr_count) &
                               (count_q == cmpb_q);
      flag_set[TCR_BIT_CMPA] = tick_i & ~(block_q | wr_count) &
                               (count_q == cmpa_q);
      flag_set[TCR_BIT_WRAP] = wrap_evt;
   end

   // clear by vector or written one
   always_comb begin
      flag_clr = 8'h00;
      flag_clr[TCR_BIT_CAPT] = vector_ack_i[3];
      flag_clr[TCR_BIT_CMPB] = vector_ack_i[2];
      flag_clr[TCR_BIT_CMPA] = vector_ack_i[1];
      flag_clr[TCR_BIT_WRAP] = vector_ack_i[0];
      if (wr_i && addr_i == TCR_OFS_FLAGS) begin
         flag_clr = flag_clr | wdata_i;
      end
   end

   // A new event outranks a clear in the same cycle so none is lost.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flags_q <= TCR_RST_BYTE;
      end else if (clk_en_i) begin
         flags_q <= ((flags_q & ~flag_clr) | flag_set) & TCR_MASK_VALID;
      end
   end

   // Count and capture high-byte reads return the latch so a low-first read pair is coherent.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= TCR_RST_BYTE;
      end else if (clk_en_i && rd_i) begin
         case (addr_i)
            TCR_OFS_IRQ_MASK: rdata_q <= mask_q;
            TCR_OFS_FLAGS:    rdata_q <= flags_q;
            TCR_OFS_COUNT_LO: rdata_q <= count_q[7:0];
            TCR_OFS_CAPT_LO:  rdata_q <= capture_q[7:0];
            TCR_OFS_CMPA_LO:  rdata_q <= cmpa_q[7:0];
            TCR_OFS_CMPB_LO:  rdata_q <= cmpb_q[7:0];
            TCR_OFS_COUNT_HI: rdata_q <= shadow_q;
            TCR_OFS_CAPT_HI:  rdata_q <= shadow_q;
            TCR_OFS_CMPA_HI:  rdata_q <= cmpa_q[15:8];
            TCR_OFS_CMPB_HI:  rdata_q <= cmpb_q[15:8];
            default:          rdata_q <= TCR_RST_BYTE;
         endcase
      end
   end

   assign irq_o = {mask_q[TCR_BIT_CAPT] & flags_q[TCR_BIT_CAPT],
                   mask_q[TCR_BIT_CMPB] & flags_q[TCR_BIT_CMPB],
                   mask_q[TCR_BIT_CMPA] & flags_q[TCR_BIT_CMPA],
                   mask_q[TCR_BIT_WRAP] & flags_q[TCR_BIT_WRAP]} &
                  {4{global_irq_enable_i}};

   assign rdata_o         = rdata_q;
   assign running_count_o = count_q;
   assign capture_value_o = capture_q;
   assign capture_event_o = cap_evt;
   assign flags_o         = flags_q;
endmodule

/* File: rtl/tcr_pkg.sv */
// Package with register map, field positions and reset values of the timer.
package tcr_pkg;
   localparam logic [7:0] TCR_OFS_IRQ_MASK   = 8'h6f;
   localparam logic [7:0] TCR_OFS_COUNT_LO   = 8'h84;
   localparam logic [7:0] TCR_OFS_COUNT_HI   = 8'h85;
   localparam logic [7:0] TCR_OFS_CAPT_LO    = 8'h86;
   localparam logic [7:0] TCR_OFS_CAPT_HI    = 8'h87;
   localparam logic [7:0] TCR_OFS_CMPA_LO    = 8'h88;
   localparam logic [7:0] TCR_OFS_CMPA_HI    = 8'h89;
   localparam logic [7:0] TCR_OFS_CMPB_LO    = 8'h8a;
   localparam logic [7:0] TCR_OFS_CMPB_HI    = 8'h8b;
   localparam logic [7:0] TCR_OFS_FLAGS      = 8'h36;
   localparam int         TCR_BIT_CAPT       = 5;
   localparam int         TCR_BIT_CMPB       = 2;
   localparam int         TCR_BIT_CMPA       = 1;
   localparam int         TCR_BIT_WRAP       = 0;
   localparam logic [7:0] TCR_MASK_VALID     = 8'h27;
   localparam logic [7:0] TCR_RST_BYTE       = 8'h00;
   localparam logic [15:0] TCR_RST_WORD      = 16'h0000;
   localparam logic [15:0] TCR_COUNT_MAX     = 16'hffff;
endpackage

/* File: rtl/tcr_edge_detect.sv */
// Capture input edge detector with selectable polarity.
`timescale 1ns/1ps
module tcr_edge_detect
   import tcr_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rstn_i,
   input  wire logic en_i,
   input  wire logic level_i,
   input  wire logic rising_i,
   output logic      edge_o
);
   logic last_q;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_q <= 1'b0;
      end else if (en_i) begin
         last_q <= level_i;
      end
   end

   assign edge_o = en_i & (rising_i ? (level_i & ~last_q)
                                    : (~level_i & last_q));
endmodule

/* File: rtl/tcr_compare_unit.sv */
// One output compare channel with match flag timing and blocking.
`timescale 1ns/1ps
module tcr_compare_unit
   import tcr_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   input  wire logic        en_i,
   input  wire logic        tick_i,
   input  wire logic        block_i,
   input  wire logic [15:0] count_i,
   input  wire logic [15:0] compare_i,
   output logic             match_o
);
   logic match_q;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match_q <= 1'b0;
      end else if (en_i) begin
         match_q <= tick_i & ~block_i & (count_i == compare_i);
      end
   end

   assign match_o = match_q;
endmodule

/* File: test/tcr_timer16_regs_monitor.sv */
// Port checker of the timer register file.
`timescale 1ns/1ps
module tcr_timer16_regs_monitor
   import tcr_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        clk_en_i,
   input wire logic [7:0]  addr_i,
   input wire logic        wr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic        tick_i,
   input wire logic        global_irq_enable_i,
   input wire logic [3:0]  vector_ack_i,
   input wire logic [15:0] running_count_o,
   input wire logic [15:0] capture_value_o,
   input wire logic        match_a_o,
   input wire logic        match_b_o,
   input wire logic        capture_event_o,
   input wire logic [7:0]  flags_o,
   input wire logic [3:0]  irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   property p_wr_lo;
      clk_en_i && wr_i && addr_i == TCR_OFS_COUNT_LO
         |=> running_count_o[7:0] == $past(wdata_i);
   endproperty
   a_wr_lo: assert property (p_wr_lo) else $error("count low lost");
   property p_block;
      clk_en_i && wr_i && addr_i == TCR_OFS_COUNT_LO
         |=> (!match_a_o && !match_b_o) [*2];
   endproperty
   a_block: assert property (p_block) else $error("match not blocked");
   property p_match_a;
      match_a_o |-> $past(tick_i) && flags_o[TCR_BIT_CMPA];
   endproperty
   a_match_a: assert property (p_match_a) else $error("match a bad");
   property p_match_b;
      match_b_o |-> $past(tick_i) && flags_o[TCR_BIT_CMPB];
   endproperty
   a_match_b: assert property (p_match_b) else $error("match b bad");
   property p_irq;
      |irq_o |-> global_irq_enable_i
         && (irq_o & ~{flags_o[5], flags_o[2:0]}) == 4'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("request bad");
   property p_rsv;
      (flags_o & ~TCR_MASK_VALID) == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved flag set");
   property p_capt;
      clk_en_i && capture_event_o |=> flags_o[TCR_BIT_CAPT]
         && capture_value_o == $past(running_count_o);
   endproperty
   a_capt: assert property (p_capt) else $error("capture bad");
   property p_ack;
      clk_en_i && vector_ack_i[1] |=> !flags_o[TCR_BIT_CMPA] || match_a_o;
   endproperty
   a_ack: assert property (p_ack) else $error("flag not cleared");
endmodule
bind tcr_timer16_regs tcr_timer16_regs_monitor u_mon (
   .mclk_i, .rstn_i, .clk_en_i, .addr_i, .wr_i, .wdata_i, .tick_i,
   .global_irq_enable_i, .vector_ack_i, .running_count_o,
   .capture_value_o, .match_a_o, .match_b_o, .capture_event_o,
   .flags_o, .irq_o);

/* File: test/tcr_core_model.sv */
// Processor core model driving the byte register bus.
`timescale 1ns/1ps
module tcr_core_model (
   input  wire logic       mclk_i,
   input  wire logic [7:0] rdata_i,
   output logic [7:0]      addr_o = 8'h00,
   output logic            wr_o = 1'b0,
   output logic            rd_o = 1'b0,
   output logic [7:0]      wdata_o = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= v;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
      // Stale data is inverted so a late sample cannot look right.
      wdata_o <= ~v;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a + 8'h01, v[15:8]);
      wr(a, v[7:0]);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 8'h01, v[15:8]);
   endtask
endmodule

/* File: test/tcr_timer16_regs_test.sv */
// Self-checking bench of the timer register file.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tcr_timer16_regs_test;
   import tcr_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        tick = 1'b0;
   logic        run = 1'b0;
   logic        pin = 1'b0;
   logic        sel = 1'b0;
   logic        topcap = 1'b0;
   logic        gie = 1'b0;
   logic [3:0]  ack = 4'h0;
   logic [7:0]  addr, wdata, rdata, d;
   logic        wr, rd;
   logic [15:0] cnt, cap, w;
   logic [7:0]  flags;
   logic [3:0]  irq;
   int          fail_count = 0;
   int          n_checks = 0;
   tcr_core_model u_core (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
      .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
   tcr_timer16_regs dut (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .clk_en_i(1'b1), .addr_i(addr),
      .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
      .tick_i(tick), .run_i(run), .top_is_capture_i(topcap),
      .top_i(16'hffff), .capture_input_pin_i(pin), .comparator_i(1'b0),
      .use_comparator_i(1'b0), .capture_edge_select_i(sel),
      .global_irq_enable_i(gie), .vector_ack_i(ack),
      .running_count_o(cnt), .capture_value_o(cap), .match_a_o(),
      .match_b_o(), .capture_event_o(), .flags_o(flags), .irq_o(irq));
   always #5 mclk_i = ~mclk_i;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_flag(input int b);
      for (int i = 0; i < 40; i++) begin
         if (flags[b] === 1'b1) return;
         @(posedge mclk_i);
         #1;
      end
      fail_count++;
      give_verdict();
   endtask
   initial begin
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         u_core.rd(TCR_OFS_COUNT_LO + 8'(i), d);
         `CHK(d, TCR_RST_BYTE)
      end
      u_core.rd(TCR_OFS_IRQ_MASK, d);
      `CHK(d, TCR_RST_BYTE)
      u_core.wr(TCR_OFS_IRQ_MASK, 8'hff);
      u_core.rd(TCR_OFS_IRQ_MASK, d);
      `CHK(d, TCR_MASK_VALID)
      u_core.rd(8'h40, d);
      `CHK(d, 8'h00)
      u_core.wr16(TCR_OFS_COUNT_LO, 16'h1234);
      `CHK(cnt, 16'h1234)
      u_core.rd16(TCR_OFS_COUNT_LO, w);
      `CHK(w, 16'h1234)
      u_core.wr16(TCR_OFS_CMPA_LO, 16'habcd);
      u_core.wr(TCR_OFS_CMPA_HI, 8'h55);
      u_core.rd(TCR_OFS_COUNT_HI, d);
      `CHK(d, 8'h55)
      u_core.rd16(TCR_OFS_CMPA_LO, w);
      `CHK(w, 16'habcd)
      $display("register access test done");
      u_core.wr16(TCR_OFS_CMPA_LO, 16'h0010);
      u_core.wr16(TCR_OFS_CMPB_LO, 16'h0020);
      u_core.wr16(TCR_OFS_COUNT_LO, 16'h000c);
      @(posedge mclk_i);
      gie <= 1'b1;
      tick <= 1'b1;
      run <= 1'b1;
      wait_flag(TCR_BIT_CMPA);
      `CHK(cnt, 16'h0011)
      `CHK(irq[1], 1'b1)
      @(posedge mclk_i);
      gie <= 1'b0;
      ack <= 4'h2;
      @(posedge mclk_i);
      ack <= 4'h0;
      #1;
      `CHK(irq[1], 1'b0)
      `CHK(flags[TCR_BIT_CMPA], 1'b0)
      // deliberate write to a running count, so its match is lost.
      u_core.wr16(TCR_OFS_COUNT_LO, 16'h0020);
      repeat (4) @(posedge mclk_i);
      #1;
      `CHK(flags[TCR_BIT_CMPB], 1'b0)
      u_core.wr16(TCR_OFS_COUNT_LO, 16'h001e);
      wait_flag(TCR_BIT_CMPB);
      `CHK(cnt, 16'h0021)
      u_core.wr(TCR_OFS_FLAGS, 8'h04);
      `CHK(flags[TCR_BIT_CMPB], 1'b0)
      $display("compare test done");
      @(posedge mclk_i);
      tick <= 1'b0;
      run <= 1'b0;
      sel <= 1'b1;
      u_core.wr16(TCR_OFS_COUNT_LO, 16'h0777);
      @(posedge mclk_i);
      pin <= 1'b1;
      wait_flag(TCR_BIT_CAPT);
      `CHK(cap, 16'h0777)
      u_core.rd16(TCR_OFS_CAPT_LO, w);
      `CHK(w, 16'h0777)
      u_core.wr(TCR_OFS_FLAGS, 8'h20);
      sel <= 1'b0;
      u_core.wr16(TCR_OFS_COUNT_LO, 16'h0123);
      @(posedge mclk_i);
      pin <= 1'b0;
      wait_flag(TCR_BIT_CAPT);
      `CHK(cap, 16'h0123)
      u_core.wr(TCR_OFS_FLAGS, 8'h20);
      topcap <= 1'b1;
      sel <= 1'b1;
      pin <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1;
      `CHK(cap, 16'h0123)
      `CHK(flags[TCR_BIT_CAPT], 1'b0)
      $display("capture test done");
      give_verdict();
   end
endmodule
